/* pslc_ctrl.sv */
// power save, peripheral bus divider and module disable lock controller
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pslc_ctrl
    import pslc_pkg::*;
#(
    parameter int NPERIPH = 8,
    parameter int OSC_START = OSC_START_CYC,
    parameter int PLL_LOCK = PLL_LOCK_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [1:0] periph_bus_divider_default,
    input wire logic module_disable_one_way,
    input wire logic wait_instr,
    input wire logic irq_req,
    input wire logic irq_sleep_capable,
    input wire logic [PRIO_W-1:0] irq_prio,
    input wire logic [PRIO_W-1:0] cpu_prio,
    input wire logic watchdog_timeout,
    input wire logic clk_switch_req,
    input wire logic clk_switch_slow,
    input wire logic clk_switch_pll,
    input wire logic periph_rd_req,
    output logic periph_rd_done,
    output logic cpu_run,
    output logic periph_bus_clock_en,
    output logic [NPERIPH-1:0] periph_run,
    output logic system_clock_blocks_en,
    output logic clk_switch_busy
);
    import pslc_pkg::*;

    pslc_state_e state;
    logic sleep_select;
    logic [1:0] periph_bus_divider;
    logic module_disable_lock;
    logic [31:0] module_disable_regs;
    logic [NPERIPH-1:0] stop_in_idle;
    logic [1:0] unlock_stage;
    logic [2:0] div_cnt;
    logic [2:0] div_mask;
    logic bus_edge;
    logic rd_pending;
    logic [31:0] delay_cnt;
    logic wake_hi;
    logic is_wr_osc;
    logic is_wr_cfg;
    logic is_wr_key;
    logic unlocked;
    logic is_wr_mod;
    logic is_wr_stop;
    pslc_state_e next_state;
    logic [31:0] next_rdata;
    logic [NPERIPH-1:0] next_periph_run;
    logic wdt_meta;
    logic wdt_sync;
    logic [31:0] next_delay_cnt;
    logic next_switch_busy;

    // wait, interrupt and switch requests come from core logic on ref_clk
    assign wake_hi = irq_req && (irq_prio > cpu_prio);
    assign is_wr_osc = reg_wr && reg_addr == OFS_OSC_CTRL;
    assign is_wr_cfg = reg_wr && reg_addr == OFS_CFG_CTRL;
    assign is_wr_key = reg_wr && reg_addr == OFS_SYS_KEY;
    assign is_wr_mod = reg_wr && reg_addr == OFS_MOD_DIS;
    assign is_wr_stop = reg_wr && reg_addr == OFS_STOP_IDLE;
    assign unlocked = unlock_stage == 2'd2;

    // watchdog runs from its own low-power oscillator; two flops before use
    // its time-out pulse must last at least one ref_clk cycle to be seen
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdt_meta <= 1'b0;
            wdt_sync <= 1'b0;
        end
        else
        begin
            wdt_meta <= watchdog_timeout;
            wdt_sync <= wdt_meta;
        end
    end

    // next power state from wait, wake and watchdog events
    always_comb
    begin
        next_state = state;
        unique case (state)
            PS_RUN:
                if (wait_instr)
                    next_state = sleep_select ? PS_SLEEP : PS_IDLE;
            PS_IDLE:
                if (wake_hi || wdt_sync)
                    next_state = PS_RUN;
            PS_SLEEP:
                if (wdt_sync)
                    next_state = PS_RUN;
                else if (irq_req && irq_sleep_capable)
                    next_state = wake_hi ? PS_RUN : PS_IDLE;
            default:
                next_state = PS_RUN;
        endcase
    end

    // asynchronous reset returns to run
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= PS_RUN;
        else
            state <= next_state;
    end

    always_comb
    begin
        for (int i = 0; i < NPERIPH; i++)
            next_periph_run[i] = (state == PS_RUN) ||
                (state == PS_IDLE && !stop_in_idle[i]);
    end

    // clock gating outputs follow the state one cycle later
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cpu_run <= 1'b1;
            periph_run <= '1;
            system_clock_blocks_en <= 1'b1;
        end
        else
        begin
            cpu_run <= state == PS_RUN;
            system_clock_blocks_en <= state != PS_SLEEP;
            periph_run <= next_periph_run;
        end
    end

    // bus clock divider: one-cycle enable pulses at 1/2^code of ref_clk
    // one free counter with a mask, so a new ratio applies at once
    always_comb
    begin
        unique case (periph_bus_divider)
            2'b00: div_mask = 3'h0;
            2'b01: div_mask = 3'h1;
            2'b10: div_mask = 3'h3;
            2'b11: div_mask = 3'h7;
        endcase
    end
    assign bus_edge = (div_cnt & div_mask) == div_mask;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt <= 3'h0;
            periph_bus_clock_en <= 1'b0;
        end
        else
        begin
            div_cnt <= div_cnt + 3'h1;
            periph_bus_clock_en <= bus_edge && state != PS_SLEEP;
        end
    end

    // peripheral read waits for the next bus clock edge, 0..7 extra at 1:8
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_pending <= 1'b0;
            periph_rd_done <= 1'b0;
        end
        else
        begin
            periph_rd_done <= (rd_pending || periph_rd_req) && bus_edge;
            if (bus_edge)
                rd_pending <= 1'b0;
            else if (periph_rd_req)
                rd_pending <= 1'b1;
        end
    end

    // clock switch delay; leaving idle never goes through here
    always_comb
    begin
        next_delay_cnt = delay_cnt;
        next_switch_busy = clk_switch_busy;
        if (clk_switch_req && !clk_switch_busy && !clk_switch_slow)
        begin
            next_delay_cnt = clk_switch_pll ? 32'(OSC_START + PLL_LOCK)
                : 32'(OSC_START);
            next_switch_busy = 1'b1;
        end
        else if (delay_cnt > 32'h1)
            next_delay_cnt = delay_cnt - 32'h1;
        else
        begin
            next_delay_cnt = 32'h0;
            next_switch_busy = 1'b0;
        end
    end

    // a request while busy is dropped; software polls the busy flag first
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            delay_cnt <= 32'h0;
            clk_switch_busy <= 1'b0;
        end
        else
        begin
            delay_cnt <= next_delay_cnt;
            clk_switch_busy <= next_switch_busy;
        end
    end

    // unlock sequence: key1 then key2 on back-to-back accesses
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            unlock_stage <= 2'd0;
        else if (is_wr_key && reg_wdata == UNLOCK_KEY1)
            unlock_stage <= 2'd1;
        else if (is_wr_key && reg_wdata == UNLOCK_KEY2 && unlock_stage == 2'd1)
            unlock_stage <= 2'd2;
        else if (is_wr_cfg && unlocked)
            unlock_stage <= 2'd0;
        else if ((reg_wr || reg_rd) && !unlocked)
            unlock_stage <= 2'd0;
    end

    // lock bit; reset clears it, one-way keeps it set
    // one-way refuses only the clear, so a second set is harmless
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            module_disable_lock <= 1'b0;
        else if (is_wr_cfg && unlocked)
        begin
            if (reg_wdata[LOCK_BIT])
                module_disable_lock <= 1'b1;
            else if (!(module_disable_one_way && module_disable_lock))
                module_disable_lock <= 1'b0;
        end
    end

    // module disable and stop-in-idle registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            module_disable_regs <= MOD_DIS_RESET;
        else if (is_wr_mod && !module_disable_lock)
            module_disable_regs <= reg_wdata;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            stop_in_idle <= NPERIPH'(STOP_IDLE_RESET);
        else if (is_wr_stop)
            stop_in_idle <= reg_wdata[NPERIPH-1:0];
    end

    // oscillator control; divider default captured on the first clock after reset
    logic div_loaded;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleep_select <= 1'b0;
            periph_bus_divider <= 2'b00;
            div_loaded <= 1'b0;
        end
        else if (!div_loaded)
        begin
            periph_bus_divider <= periph_bus_divider_default;
            div_loaded <= 1'b1;
        end
        else if (is_wr_osc)
        begin
            sleep_select <= reg_wdata[SLEEP_SELECT_BIT];
            periph_bus_divider <= reg_wdata[DIV_HI_BIT:DIV_LO_BIT];
        end
    end

    // read mux; zero outside the read slot
    always_comb
    begin
        next_rdata = 32'h0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_OSC_CTRL:
                    next_rdata = (32'(sleep_select) << SLEEP_SELECT_BIT) |
                        (32'(periph_bus_divider) << DIV_LO_BIT);
                OFS_CFG_CTRL:
                    next_rdata = (32'(module_disable_lock) << LOCK_BIT) |
                        (32'(module_disable_one_way) << ONE_WAY_BIT);
                OFS_MOD_DIS: next_rdata = module_disable_regs;
                OFS_POWER_STAT: next_rdata = {28'h0, clk_switch_busy, unlocked, 2'(state)};
                OFS_STOP_IDLE: next_rdata = 32'(stop_in_idle);
                default: next_rdata = 32'h0;
            endcase
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0;
        else
            reg_rdata <= next_rdata;
    end
endmodule
`default_nettype wire

/* pslc_pkg.sv */
// package of constants for the power save and clock lock controller
package pslc_pkg;
    // register offsets (plain port, word index)
    localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
    localparam logic [3:0] OFS_CFG_CTRL = 4'h1;
    localparam logic [3:0] OFS_SYS_KEY = 4'h2;
    localparam logic [3:0] OFS_MOD_DIS = 4'h3;
    localparam logic [3:0] OFS_POWER_STAT = 4'h4;
    localparam logic [3:0] OFS_STOP_IDLE = 4'h5;
    // field positions
    localparam int SLEEP_SELECT_BIT = 4;
    localparam int DIV_LO_BIT = 19;
    localparam int DIV_HI_BIT = 20;
    localparam int LOCK_BIT = 12;
    localparam int ONE_WAY_BIT = 28;
    // unlock keys (arbitrary values)
    localparam logic [31:0] UNLOCK_KEY1 = 32'hAA99_6655;
    localparam logic [31:0] UNLOCK_KEY2 = 32'h5566_99AA;
    // reset values
    localparam logic [31:0] MOD_DIS_RESET = 32'h0000_0000;
    localparam logic [31:0] STOP_IDLE_RESET = 32'h0000_0000;
    // priorities
    localparam int PRIO_W = 3;
    // oscillator start-up time and PLL lock time, in us
    localparam int OSC_START_US = 10;
    localparam int PLL_LOCK_US = 20;
    localparam int CLK_MHZ = 100;
    localparam int OSC_START_CYC = OSC_START_US * CLK_MHZ;
    localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
    // power states
    typedef enum logic [1:0]
    {
        PS_RUN = 2'b00,
        PS_IDLE = 2'b01,
        PS_SLEEP = 2'b10
    } pslc_state_e;
endpackage

/* pslc_ctrl_sva.sv */
// assertion checker for the power save and clock lock controller
`timescale 1ns/1ps
`default_nettype none
module pslc_ctrl_chk
    import pslc_pkg::*;
#(
    parameter int NPERIPH = 8
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic wait_instr,
    input wire logic irq_req,
    input wire logic [PRIO_W-1:0] irq_prio,
    input wire logic [PRIO_W-1:0] cpu_prio,
    input wire logic watchdog_timeout,
    input wire logic periph_rd_req,
    input wire logic periph_rd_done,
    input wire logic periph_bus_clock_en,
    input wire logic cpu_run,
    input wire logic [NPERIPH-1:0] periph_run,
    input wire logic clk_switch_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    property p_done_edge; periph_rd_done |-> periph_bus_clock_en; endproperty
    property p_rd_bound; periph_rd_req |-> ##[1:9] periph_rd_done; endproperty
    property p_wait; cpu_run && wait_instr && !irq_req && !watchdog_timeout |-> ##2 !cpu_run;
    endproperty
    // a wake traces to an interrupt two cycles back or a synchronised watchdog four back
    property p_wake;
        $rose(cpu_run) |-> $past(irq_req && irq_prio > cpu_prio, 2) ||
            $past(watchdog_timeout, 4);
    endproperty
    property p_busy_end; $rose(clk_switch_busy) |-> ##[1:12] !clk_switch_busy; endproperty
    property p_pb_pulse; (cpu_run && !periph_bus_clock_en) [*8] |=> periph_bus_clock_en;
    endproperty
    property p_run_all; cpu_run [*3] |-> periph_run == {NPERIPH{1'b1}}; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    a_done_edge: assert property (p_done_edge) else $error("read done off bus edge");
    a_rd_bound: assert property (p_rd_bound) else $error("read not completed");
    a_wait: assert property (p_wait) else $error("wait did not halt cpu");
    a_wake: assert property (p_wake) else $error("cpu woke without cause");
    a_busy_end: assert property (p_busy_end) else $error("start-up delay too long");
    a_pb_pulse: assert property (p_pb_pulse) else $error("bus clock too slow");
    a_run_all: assert property (p_run_all) else $error("peripheral halted in run");
    c_halt: cover property ($fell(cpu_run));
    c_busy: cover property ($rose(clk_switch_busy));
    c_rd: cover property (periph_rd_done);
endmodule
bind pslc_ctrl pslc_ctrl_chk #(.NPERIPH(NPERIPH)) u_pslc_ctrl_chk (.*);
`default_nettype wire

/* pslc_periph_model.sv */
// peripheral-side model: issues one bus read and times its completion
`timescale 1ns/1ps
`default_nettype none
module pslc_periph_model
(
    input wire logic ref_clk,
    input wire logic go,
    input wire logic periph_rd_done,
    output logic periph_rd_req,
    output int lat
);
    initial
    begin
        periph_rd_req = 1'b0;
        lat = 0;
        forever
        begin
            @(posedge ref_clk);
            if (go)
            begin
                periph_rd_req <= 1'b1;
                @(posedge ref_clk);
                periph_rd_req <= 1'b0;
                lat = 0;
                // bounded so a lost completion cannot hang the run
                while (lat < 16 && periph_rd_done !== 1'b1)
                begin
                    #1 lat++;
                    @(posedge ref_clk);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* power_save_clock_lock_ctrl_tb.sv */
// self-checking testbench of the power save and clock lock controller
`timescale 1ns/1ps
`default_nettype none
module power_save_clock_lock_ctrl_tb;
    import pslc_pkg::*;
    localparam logic [31:0] LK = 32'h0000_1000;
    localparam logic [31:0] OW = 32'h1000_0000;
    logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
    logic wait_instr = 1'b0, irq_req = 1'b0, watchdog_timeout = 1'b0, clk_switch_req = 1'b0;
    logic irq_sleep_capable = 1'b0, clk_switch_slow = 1'b0, clk_switch_pll = 1'b1;
    logic module_disable_one_way = 1'b0, periph_rd_req, periph_rd_done, cpu_run;
    logic periph_bus_clock_en, system_clock_blocks_en, clk_switch_busy;
    logic [1:0] periph_bus_divider_default = 2'h3;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [PRIO_W-1:0] irq_prio = 3'h3, cpu_prio = 3'h3;
    logic [7:0] periph_run;
    int errors = 0, checks_done = 0, lat, n;
    pslc_ctrl #(.NPERIPH(8), .OSC_START(5), .PLL_LOCK(5)) u_pslc_ctrl (.*);
    pslc_periph_model u_pslc_periph_model (.*);
    initial forever #5 ref_clk = ~ref_clk;
    task give_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task acc(input logic w, input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'h0;
        #1 d = reg_rdata;
    endtask
    task rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
        acc(1'b0, a, 32'h0);
        chk(s, e, d & m);
    endtask
    task unlock();
        acc(1'b1, OFS_SYS_KEY, UNLOCK_KEY1);
        acc(1'b1, OFS_SYS_KEY, UNLOCK_KEY2);
    endtask
    // one-cycle event: 0 wait, 1 interrupt, 2 watchdog, 3 clock switch
    task ev(input int k);
        @(posedge ref_clk);
        wait_instr <= k == 0;
        irq_req <= k == 1;
        watchdog_timeout <= k == 2;
        clk_switch_req <= k == 3;
        @(posedge ref_clk);
        {wait_instr, irq_req, watchdog_timeout, clk_switch_req} <= 4'h0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    initial
    begin
        do_reset();
        rc(OFS_OSC_CTRL, 32'h0018_0000, 32'h0018_0000, "divider default");
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b1, OFS_OSC_CTRL, i << DIV_LO_BIT);
            n = 0;
            repeat (32) @(posedge ref_clk) #1 n += periph_bus_clock_en;
            chk("bus clock pulses", 32 >> i, n);
        end
        go <= 1'b1;
        @(posedge ref_clk) go <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk("read latency", 32'h1, lat >= 1 && lat <= 9);
        chk("system clock blocks", 32'h1, system_clock_blocks_en);
        $display("divider test done");
        acc(1'b1, OFS_MOD_DIS, 32'h0000_005A);
        rc(OFS_MOD_DIS, 32'hFFFF_FFFF, 32'h0000_005A, "disable open");
        unlock();
        acc(1'b1, OFS_CFG_CTRL, LK);
        acc(1'b1, OFS_MOD_DIS, 32'h0000_00FF);
        rc(OFS_MOD_DIS, 32'hFFFF_FFFF, 32'h0000_005A, "disable locked");
        acc(1'b1, OFS_CFG_CTRL, 32'h0);
        rc(OFS_CFG_CTRL, LK, LK, "lock no unlock");
        acc(1'b1, OFS_SYS_KEY, UNLOCK_KEY1);
        acc(1'b0, OFS_MOD_DIS, 32'h0);
        acc(1'b1, OFS_SYS_KEY, UNLOCK_KEY2);
        acc(1'b1, OFS_CFG_CTRL, 32'h0);
        rc(OFS_CFG_CTRL, LK, LK, "lock cancelled unlock");
        unlock();
        acc(1'b1, OFS_CFG_CTRL, 32'h0);
        rc(OFS_CFG_CTRL, LK, 32'h0, "lock cleared");
        rc(4'hF, 32'hFFFF_FFFF, 32'h0, "unmapped");
        module_disable_one_way <= 1'b1;
        do_reset();
        rc(OFS_CFG_CTRL, LK | OW, OW, "one-way strap");
        unlock();
        acc(1'b1, OFS_CFG_CTRL, LK);
        unlock();
        acc(1'b1, OFS_CFG_CTRL, 32'h0);
        rc(OFS_CFG_CTRL, LK, LK, "one-way lock");
        do_reset();
        rc(OFS_CFG_CTRL, LK, 32'h0, "lock after reset");
        $display("lock test done");
        acc(1'b1, OFS_STOP_IDLE, 32'h0000_000F);
        ev(0);
        chk("idle cpu", 32'h0, cpu_run);
        chk("idle peripherals", 32'hF0, periph_run);
        chk("idle system clock", 32'h1, system_clock_blocks_en);
        ev(1);
        chk("equal priority", 32'h0, cpu_run);
        irq_prio <= 3'h4;
        ev(1);
        chk("higher priority", 32'h1, cpu_run);
        chk("idle exit delay", 32'h0, clk_switch_busy);
        ev(0);
        ev(2);
        chk("watchdog idle", 32'h1, cpu_run);
        acc(1'b1, OFS_OSC_CTRL, 32'h0000_0010);
        irq_sleep_capable <= 1'b1;
        irq_prio <= 3'h2;
        ev(0);
        rc(OFS_POWER_STAT, 32'h3, PS_SLEEP, "sleep entry");
        chk("sleep system clock", 32'h0, system_clock_blocks_en);
        ev(1);
        rc(OFS_POWER_STAT, 32'h3, PS_IDLE, "low wake");
        ev(2);
        ev(0);
        ev(2);
        chk("watchdog sleep", 32'h1, cpu_run);
        irq_prio <= 3'h5;
        ev(0);
        ev(1);
        chk("sleep wake", 32'h1, cpu_run);
        $display("power test done");
        ev(3);
        chk("start-up delay", 32'h1, clk_switch_busy);
        n = 0;
        while (clk_switch_busy !== 1'b0 && n < 20) @(posedge ref_clk) n++;
        chk("delay ends", 32'h1, n < 20);
        if (n >= 20)
            give_verdict();
        $display("clock switch test done");
        give_verdict();
    end
endmodule
`default_nettype wire
